// *** rut_regs.vh ***
`ifndef RUT_REGS_VH
`define RUT_REGS_VH

// timer register block stride and registers inside one block
`define RUT_TMR_STRIDE     8'h10
`define RUT_OFS_CTRL       8'h00
`define RUT_OFS_COUNT      8'h04
`define RUT_OFS_RELOAD     8'h08

// shared registers
`define RUT_OFS_STATUS     8'h30
`define RUT_OFS_MASK       8'h34
`define RUT_OFS_PINS       8'h38

// control fields
`define RUT_CTRL_EN        0
`define RUT_CTRL_POL       1
`define RUT_CTRL_OUTEN     2
`define RUT_CTRL_PRE_LO    4
`define RUT_CTRL_PRE_HI    6
`define RUT_CTRL_ALTEN     8

// status and mask fields: bits 0..2 timeout per timer, bit 3 timer zero input change
`define RUT_ST_INPUT       3
`define RUT_ST_W           4

// reset values
`define RUT_RST_COUNT      16'h0001
`define RUT_RST_RELOAD     16'h0000
`define RUT_RST_CTRL       9'h000
`define RUT_RST_MASK       4'h0
`define RUT_RELOAD_START   16'h0001

// timing
`define RUT_PRE_MAX_LOG2   3'h7
`define RUT_SYNC_STAGES    3

`endif

// *** rut_timer_core.v ***
`timescale 1ns/100ps
`include "rut_regs.vh"

module rut_timer_core #(
  parameter CW = 16,
  parameter PW = 3
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ctrl_we,
  input  wire          ctrl_en_wd,
  input  wire          cnt_we,
  input  wire [CW-1:0] cnt_wd,
  input  wire [CW-1:0] reload,
  input  wire [PW-1:0] pre_sel,
  input  wire          polarity,
  output reg  [CW-1:0] count,
  output reg           running,
  output reg           timeout,
  output reg           tout
);

  reg  [6:0] pre_cnt;
  wire [7:0] pre_span;
  wire [6:0] pre_top;
  wire       tick;
  wire       hit;

  // divide by 2**pre_sel: 1, 2, 4 .. 128
  assign pre_span = 8'h01 << pre_sel;
  assign pre_top  = pre_span[6:0] - 7'h01;
  assign tick     = running & (pre_cnt == pre_top);
  // equality only: a reload below the count wraps through FFFF and 0000 first
  assign hit      = tick & (count == reload);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      pre_cnt <= 7'h00;
      count   <= `RUT_RST_COUNT;
      timeout <= 1'b0;
      tout    <= 1'b0;
    end else begin
      // a software write to enable overrides the self clear of the same cycle
      if (ctrl_we) begin
        running <= ctrl_en_wd;
      end else if (hit) begin
        running <= 1'b0;
      end
      if (!running || tick) begin
        pre_cnt <= 7'h00;
      end else begin
        pre_cnt <= pre_cnt + 7'h01;
      end
      // loads only while stopped so a running period is never disturbed
      if (cnt_we && !running) begin
        count <= cnt_wd;
      end else if (hit) begin
        count <= `RUT_RELOAD_START;
      end else if (tick) begin
        count <= count + {{(CW-1){1'b0}}, 1'b1};
      end
      timeout <= hit;
      tout    <= polarity ^ hit;
    end
  end

endmodule // rut_timer_core

// *** rut_timer_top.v ***
`timescale 1ns/100ps
`include "rut_regs.vh"

// Contract
// - three independent sixteen bit reloadable timers
// - count up, initial count value 0001H
// - at reload value return to 0001H
// - prescaler divides system clock 1 to 128
// - reload 0001H, prescale 1: one clock
// - reload 0000H wraps FFFFH to 0000H, longest
// - reload below count: wrap, then reach reload
// - any alternate timer zero input acts alike
// - single shot: interrupt, reload 0001H, self disable
// - output pin inverts one clock at reload
// - timeout is (reload-start+1) times prescale clocks

module rut_timer_top #(
  parameter NT = 3,
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          rstn,
  input  wire [7:0]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  input  wire          wb_we_i,
  input  wire [3:0]    wb_sel_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  output reg           wb_ack_o,
  input  wire          timer_zero_input_pin,
  input  wire          timer_zero_alt_input_a,
  input  wire          timer_zero_alt_input_b,
  input  wire          timer_zero_alt_input_c,
  output wire [NT-1:0] timeout_req,
  output wire [NT-1:0] timer_out,
  output wire [NT-1:0] timer_out_oe,
  output wire          irq
);

  // reset release
  reg rst_s1;
  reg rst_n;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // bus decode
  wire access;
  wire wr;
  wire rd;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = access & wb_we_i;
  assign rd     = access & ~wb_we_i;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // pin inputs: pin plus three alternates, three stages each
  localparam NP = 4;

  wire [NP-1:0] pin_raw;
  reg  [NP-1:0] pin_s1;
  reg  [NP-1:0] pin_s2;
  reg  [NP-1:0] pin_s3;
  reg  [NP-1:0] pin_stable;
  reg  [NP-1:0] pin_change;
  wire          alt_en;
  wire          input_event;

  assign pin_raw = {timer_zero_alt_input_c, timer_zero_alt_input_b,
                    timer_zero_alt_input_a, timer_zero_input_pin};

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp = gp + 1) begin : g_pin
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1[gp]     <= 1'b0;
          pin_s2[gp]     <= 1'b0;
          pin_s3[gp]     <= 1'b0;
          pin_stable[gp] <= 1'b0;
          pin_change[gp] <= 1'b0;
        end else begin
          pin_s1[gp] <= pin_raw[gp];
          pin_s2[gp] <= pin_s1[gp];
          pin_s3[gp] <= pin_s2[gp];
          // a change is taken only once stages two and three agree
          if (pin_s2[gp] == pin_s3[gp]) begin
            pin_stable[gp] <= pin_s3[gp];
            pin_change[gp] <= (pin_s3[gp] != pin_stable[gp]);
          end else begin
            pin_change[gp] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // alternates count as the main input only while routed in
  assign input_event = pin_change[0] | (alt_en & (|pin_change[NP-1:1]));

  // per timer configuration
  reg  [8:0]    ctrl    [0:NT-1];
  reg  [CW-1:0] reload  [0:NT-1];
  wire [CW-1:0] count   [0:NT-1];
  wire [NT-1:0] running;
  wire [NT-1:0] timeout;
  wire [NT-1:0] tout;

  assign alt_en = ctrl[0][`RUT_CTRL_ALTEN];

  genvar gt;
  generate
    for (gt = 0; gt < NT; gt = gt + 1) begin : g_tmr
      wire [7:0] base;
      wire       sel_blk;
      wire       ctrl_we;
      wire       cnt_we;
      wire       rld_we;

      // block base kept as an integer, then cut to the address width on purpose
      localparam integer BASE_I = gt * `RUT_TMR_STRIDE;
      assign base    = BASE_I[7:0];
      assign sel_blk = (wb_adr_i[7:4] == base[7:4]);
      assign ctrl_we = wr & sel_blk & (wb_adr_i[3:0] == `RUT_OFS_CTRL);
      assign cnt_we  = wr & sel_blk & (wb_adr_i[3:0] == `RUT_OFS_COUNT);
      assign rld_we  = wr & sel_blk & (wb_adr_i[3:0] == `RUT_OFS_RELOAD);

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl[gt]   <= `RUT_RST_CTRL;
          reload[gt] <= `RUT_RST_RELOAD;
        end else begin
          if (ctrl_we) begin
            ctrl[gt] <= {wb_sel_i[1] ? wb_dat_i[8] : ctrl[gt][8],
                         wb_sel_i[0] ? wb_dat_i[7:0] : ctrl[gt][7:0]};
          end
          if (rld_we) begin
            reload[gt] <= merge16(reload[gt], wb_dat_i[15:0], wb_sel_i[1:0]);
          end
        end
      end

      rut_timer_core #(
        .CW (CW),
        .PW (3)
      ) u_core (
        .clk        (clk),
        .rst_n      (rst_n),
        .ctrl_we    (ctrl_we & wb_sel_i[0]),
        .ctrl_en_wd (wb_dat_i[`RUT_CTRL_EN]),
        .cnt_we     (cnt_we),
        .cnt_wd     (merge16(count[gt], wb_dat_i[15:0], wb_sel_i[1:0])),
        .reload     (reload[gt]),
        .pre_sel    (ctrl[gt][`RUT_CTRL_PRE_HI:`RUT_CTRL_PRE_LO]),
        .polarity   (ctrl[gt][`RUT_CTRL_POL]),
        .count      (count[gt]),
        .running    (running[gt]),
        .timeout    (timeout[gt]),
        .tout       (tout[gt])
      );

      assign timeout_req[gt]  = timeout[gt];
      assign timer_out[gt]    = tout[gt];
      assign timer_out_oe[gt] = ctrl[gt][`RUT_CTRL_OUTEN];
    end
  endgenerate

  // sticky events and mask
  reg  [`RUT_ST_W-1:0] status;
  reg  [`RUT_ST_W-1:0] mask;
  wire [`RUT_ST_W-1:0] ev;
  wire [`RUT_ST_W-1:0] w1c;
  wire                 st_we;
  wire                 mk_we;

  assign ev    = {input_event, timeout};
  assign st_we = wr & (wb_adr_i == `RUT_OFS_STATUS) & wb_sel_i[0];
  assign mk_we = wr & (wb_adr_i == `RUT_OFS_MASK) & wb_sel_i[0];
  assign w1c   = st_we ? wb_dat_i[`RUT_ST_W-1:0] : {`RUT_ST_W{1'b0}};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= {`RUT_ST_W{1'b0}};
      mask   <= `RUT_RST_MASK;
    end else begin
      // an event in the clearing cycle survives the clear
      status <= (status & ~w1c) | ev;
      if (mk_we) begin
        mask <= wb_dat_i[`RUT_ST_W-1:0];
      end
    end
  end

  assign irq = |(status & mask);

  // read mux
  reg [31:0] rdata;
  reg [1:0]  tix;

  always @* begin
    rdata = 32'h0000_0000;
    tix   = wb_adr_i[5:4];
    if (wb_adr_i == `RUT_OFS_STATUS) begin
      rdata = {28'h000_0000, status};
    end else if (wb_adr_i == `RUT_OFS_MASK) begin
      rdata = {28'h000_0000, mask};
    end else if (wb_adr_i == `RUT_OFS_PINS) begin
      rdata = {28'h000_0000, pin_stable};
    end else if (tix < NT) begin
      case (wb_adr_i[3:0])
        `RUT_OFS_CTRL: begin
          rdata = {23'h00_0000, ctrl[tix][8:1], running[tix]};
        end
        `RUT_OFS_COUNT: begin
          rdata = {16'h0000, count[tix]};
        end
        `RUT_OFS_RELOAD: begin
          rdata = {16'h0000, reload[tix]};
        end
        default: begin
          rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // one wait state: ack and data one edge after the request is seen
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (rd) begin
        wb_dat_o <= rdata;
      end
    end
  end

endmodule // rut_timer_top

// *** rut_timer_top_assertions.sv ***
`timescale 1ns/100ps
module rut_timer_top_assertions #(
  parameter NT = 3
) (
  input wire          clk,
  input wire          rstn,
  input wire [31:0]   wb_dat_o,
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire          wb_ack_o,
  input wire [NT-1:0] timeout_req,
  input wire [NT-1:0] timer_out,
  input wire [NT-1:0] timer_out_oe,
  input wire          irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_flip;
    timer_out[0] != $past(timer_out[0]);
  endsequence
  sequence s_back;
    timer_out[0] == $past(timer_out[0], 2);
  endsequence

  a_ack_answer: assert property (s_take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_req_pulse: assert property ((timeout_req & $past(timeout_req)) == 0)
    else $error("timeout request not a pulse");
  a_out_pulse: assert property (timeout_req[0] |-> s_flip ##1 s_back)
    else $error("output pulse wrong");
  // no bus write means no restart, so a second shot is a fault
  a_self_stop: assert property (timeout_req[0] ##1 !wb_ack_o [*3] |=> !timeout_req[0])
    else $error("timer kept running after timeout");
  a_irq_drop: assert property ($fell(irq) |-> wb_ack_o)
    else $error("irq fell without a bus write");
  a_oe_write: assert property (!$stable(timer_out_oe) |-> wb_ack_o)
    else $error("output enable moved without a write");
  a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
endmodule // rut_timer_top_assertions

// *** rut_timer_top_tb_top.sv ***
`timescale 1ns/100ps
module rut_timer_top_tb_top;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         we = 1'b0;
  reg         cyc = 1'b0;
  reg  [3:0]  pn = 4'h0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wd = 32'h0;
  reg  [31:0] r;
  reg  [15:0] st;
  wire [31:0] rd;
  wire        ack;
  wire        irq;
  wire [2:0]  treq;
  wire [2:0]  tout;
  wire [2:0]  toe;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     seed = 32'h03c0;
  integer     cnt = 0;
  integer     t_ack = 0;
  integer     t_to = 0;
  integer     t;

  rut_timer_top DUT (
    .clk(clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
    .timer_zero_input_pin(pn[3]), .timer_zero_alt_input_a(pn[2]),
    .timer_zero_alt_input_b(pn[1]), .timer_zero_alt_input_c(pn[0]),
    .timeout_req(treq), .timer_out(tout), .timer_out_oe(toe), .irq(irq)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  // stamps at sampling edges, so the difference is the period in cycles
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (ack && we && adr[7:4] < 4'h3 && adr[3:0] == 4'h0)
      t_ack <= cnt;
    if (|treq)
      t_to <= cnt;
  end

  task give_verdict;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t seen %h want %h", $time, s, e);
      end
    end
  endtask

  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      we  <= w;
      adr <= a;
      wd  <= d;
      cyc <= 1'b1;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20) begin
        chk(ack, 1'b1);
        give_verdict;
      end
      r = rd;
      cyc <= 1'b0;
      @(posedge clk);
    end
  endtask

  task shot(input [1:0] k, input [15:0] s, input [15:0] l, input [2:0] p);
    reg [7:0] b;
    integer   n;
    begin
      b = {2'b00, k, 4'h0};
      wb(1'b1, b, {p, 4'h6});
      wb(1'b1, b | 8'h04, s);
      wb(1'b1, b | 8'h08, l);
      wb(1'b1, b, {p, 4'h7});
      n = 0;
      while (t_to < t_ack && n < 9000) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(t_to - t_ack, ((l - s + 1) & 16'hFFFF) << p);
      if (n == 9000)
        give_verdict;
      chk(tout[k], 1'b1);
      chk(toe[k], 1'b1);
      wb(1'b0, b | 8'h04, 0);
      chk(r, 32'h1);
      wb(1'b0, b, 0);
      chk(r[0], 1'b0);
      wb(1'b0, 8'h30, 0);
      chk(r[k], 1'b1);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h04, 0);
    chk(r, 32'h1);
    wb(1'b0, 8'h08, 0);
    chk(r, 32'h0);
    wb(1'b0, 8'h3C, 0);
    chk(r, 32'h0);
    $display("reset values done");
    shot(0, 16'h0001, 16'h0001, 3'h0);
    shot(1, 16'hFFF0, 16'h0000, 3'h0);
    shot(2, 16'hFFF0, 16'h0005, 3'h1);
    shot(0, 16'h0003, 16'h0003, 3'h7);
    for (t = 0; t < 6; t = t + 1) begin
      st = $random(seed);
      shot(t % 3, st, st + ($random(seed) & 63), $random(seed));
    end
    $display("shots done");
    wb(1'b1, 8'h34, 32'h9);
    chk(irq, 1'b1);
    wb(1'b1, 8'h30, 32'hF);
    chk(irq, 1'b0);
    pn <= 4'h4;
    repeat (8) @(posedge clk);
    chk(irq, 1'b0);
    pn <= 4'h0;
    repeat (8) @(posedge clk);
    wb(1'b1, 8'h00, 32'h100);
    pn <= 4'h1;
    repeat (8) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, 8'h30, 32'hF);
    chk(irq, 1'b0);
    $display("interrupt and input done");
    wb(1'b1, 8'h00, 32'h71);
    wb(1'b1, 8'h04, 32'h55);
    wb(1'b0, 8'h04, 0);
    chk(r, 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h1234);
    wb(1'b0, 8'h04, 0);
    chk(r, 32'h1234);
    $display("count load done");
    wb(1'b1, 8'h10, 32'h4);
    wb(1'b1, 8'h18, 32'h28);
    wb(1'b1, 8'h10, 32'h5);
    wb(1'b1, 8'h10, 32'h7);
    repeat (60) @(posedge clk);
    chk(tout[1], 1'b1);
    $display("polarity done");
    give_verdict;
  end
endmodule // rut_timer_top_tb_top

bind rut_timer_top rut_timer_top_assertions #(.NT(NT)) u_chk (
  .clk(clk), .rstn(rstn), .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .timeout_req(timeout_req),
  .timer_out(timer_out), .timer_out_oe(timer_out_oe), .irq(irq)
);
